// File: owgdr_top.sv
// Purpose: Register bank, window two column width sequencer and output stages
// Assumes: Host port and video timing inputs come from logic on the same clock
// Notes: Read data appears one cycle after the read strobe
module owgdr_top
    import owgdr_pkg::*;
(
    input logic clock,
    input logic arst_n,
    input logic clock_en,
    input logic [ADDR_W-1:0] host_addr,
    input logic [DATA_W-1:0] host_wdata,
    input logic host_wr,
    input logic host_rd,
    output logic [DATA_W-1:0] host_rdata,
    output logic host_hit,
    input logic line_active,
    input logic pixel_tick,
    input logic [FONT_W-1:0] font_row,
    output logic [CHAR_W-1:0] char_index,
    output logic overlay_display_pixel,
    output logic pixel_valid,
    output logic wide_column,
    output logic [3:0] vertical_fade_step,
    output logic [3:0] horizontal_fade_step,
    output logic [GAIN_W-1:0] blue_gain,
    output logic [GAIN_W-1:0] green_gain,
    output logic [GAIN_W-1:0] red_gain,
    output logic [GAIN_W-1:0] contrast_level,
    output logic [DATA_W-1:0] dac_one_value,
    output logic [DATA_W-1:0] dac_two_value,
    output logic [DATA_W-1:0] dac_three_value,
    output logic dac_range_low
);
    logic rst_meta;
    logic rst_n;
    logic [DATA_W-1:0] wide_b0;
    logic [DATA_W-1:0] wide_b1;
    logic [DATA_W-1:0] wide_b2;
    logic [DATA_W-1:0] wide_b3;
    logic [DATA_W-1:0] fade_interval;
    logic [DATA_W-1:0] blue_gain_ctrl;
    logic [DATA_W-1:0] green_gain_ctrl;
    logic [DATA_W-1:0] red_gain_ctrl;
    logic [DATA_W-1:0] contrast_ctrl;
    logic [DATA_W-1:0] dac_one_level;
    logic [DATA_W-1:0] dac_two_level;
    logic [DATA_W-1:0] dac_three_level;
    logic full_scale_low;
    logic [MASK_W-1:0] wide_mask;
    logic [DATA_W-1:0] next_rdata;
    logic next_hit;
    owgdr_seq_state_t seq_state;
    owgdr_seq_state_t next_seq_state;
    logic [FONT_X_W-1:0] font_x;
    logic cur_wide;
    logic wr_en;

    owgdr_cfg_if cfg ();

    // Column is wide only inside the first 32 characters
    function automatic logic column_is_wide(
        input logic [CHAR_W-1:0] col,
        input logic [MASK_W-1:0] mask
    );
        column_is_wide = (col < WIDE_CHAR_LIMIT) && mask[col[4:0]];
    endfunction : column_is_wide

    // Font bits are sent leftmost first
    function automatic logic font_bit(
        input logic [FONT_W-1:0] row,
        input logic [FONT_X_W-1:0] x
    );
        font_bit = row[FONT_X_LAST - x];
    endfunction : font_bit

    // Reset release through two flops
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign wr_en = clock_en && host_wr;

    // Mask bytes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wide_b0 <= REG_RESET;
            wide_b1 <= REG_RESET;
            wide_b2 <= REG_RESET;
            wide_b3 <= REG_RESET;
        end
        else if (wr_en)
        begin
            if (host_addr == ADDR_WIDE_B0)
                wide_b0 <= host_wdata;
            else if (host_addr == ADDR_WIDE_B1)
                wide_b1 <= host_wdata;
            else if (host_addr == ADDR_WIDE_B2)
                wide_b2 <= host_wdata;
            else if (host_addr == ADDR_WIDE_B3)
                wide_b3 <= host_wdata;
        end
    end

    assign wide_mask = {wide_b3, wide_b2, wide_b1, wide_b0};

    // Fade interval
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            fade_interval <= REG_RESET;
        else if (wr_en && host_addr == ADDR_FADE)
            fade_interval <= host_wdata;
    end

    assign vertical_fade_step = fade_interval[VFADE_HI:VFADE_LO];
    assign horizontal_fade_step = fade_interval[HFADE_HI:HFADE_LO];

    // Gain and contrast, all eight bits kept so readback matches the write
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blue_gain_ctrl <= REG_RESET;
            green_gain_ctrl <= REG_RESET;
            red_gain_ctrl <= REG_RESET;
            contrast_ctrl <= REG_RESET;
        end
        else if (wr_en)
        begin
            if (host_addr == ADDR_BLUE)
                blue_gain_ctrl <= host_wdata;
            else if (host_addr == ADDR_GREEN)
                green_gain_ctrl <= host_wdata;
            else if (host_addr == ADDR_RED)
                red_gain_ctrl <= host_wdata;
            else if (host_addr == ADDR_CONTRAST)
                contrast_ctrl <= host_wdata;
        end
    end

    // DAC levels
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dac_one_level <= REG_RESET;
            dac_two_level <= REG_RESET;
            dac_three_level <= REG_RESET;
        end
        else if (wr_en)
        begin
            if (host_addr == ADDR_DAC_ONE)
                dac_one_level <= host_wdata;
            else if (host_addr == ADDR_DAC_TWO)
                dac_two_level <= host_wdata;
            else if (host_addr == ADDR_DAC_THREE)
                dac_three_level <= host_wdata;
        end
    end

    // Range select snooped from the DAC config register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            full_scale_low <= 1'b0;
        else if (wr_en && host_addr == ADDR_DAC_CONFIG)
            full_scale_low <= host_wdata[FULL_SCALE_BIT];
    end

    // Read decode
    always_comb
    begin
        next_rdata = READ_IDLE;
        next_hit = 1'b1;
        if (host_addr == ADDR_WIDE_B0)
            next_rdata = wide_b0;
        else if (host_addr == ADDR_WIDE_B1)
            next_rdata = wide_b1;
        else if (host_addr == ADDR_WIDE_B2)
            next_rdata = wide_b2;
        else if (host_addr == ADDR_WIDE_B3)
            next_rdata = wide_b3;
        else if (host_addr == ADDR_FADE)
            next_rdata = fade_interval;
        else if (host_addr == ADDR_BLUE)
            next_rdata = blue_gain_ctrl;
        else if (host_addr == ADDR_GREEN)
            next_rdata = green_gain_ctrl;
        else if (host_addr == ADDR_RED)
            next_rdata = red_gain_ctrl;
        else if (host_addr == ADDR_CONTRAST)
            next_rdata = contrast_ctrl;
        else if (host_addr == ADDR_DAC_ONE)
            next_rdata = dac_one_level;
        else if (host_addr == ADDR_DAC_TWO)
            next_rdata = dac_two_level;
        else if (host_addr == ADDR_DAC_THREE)
            next_rdata = dac_three_level;
        else
            next_hit = 1'b0;
    end

    // Read data register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_rdata <= READ_IDLE;
            host_hit <= 1'b0;
        end
        else if (clock_en)
        begin
            if (host_rd)
            begin
                host_rdata <= next_rdata;
                host_hit <= next_hit;
            end
            else
            begin
                host_rdata <= READ_IDLE;
                host_hit <= 1'b0;
            end
        end
    end

    assign cur_wide = column_is_wide(char_index, wide_mask);

    // Sequencer state: first or repeated copy of a font pixel
    always_comb
    begin
        next_seq_state = seq_state;
        case (seq_state)
            SEQ_IDLE:
                if (line_active)
                    next_seq_state = SEQ_FIRST;
            SEQ_FIRST:
                if (!line_active)
                    next_seq_state = SEQ_IDLE;
                else if (pixel_tick && cur_wide)
                    next_seq_state = SEQ_REPEAT;
            SEQ_REPEAT:
                if (!line_active)
                    next_seq_state = SEQ_IDLE;
                else if (pixel_tick)
                    next_seq_state = SEQ_FIRST;
            default:
                next_seq_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            seq_state <= SEQ_IDLE;
        else if (clock_en)
            seq_state <= next_seq_state;
    end

    // Font position and character column counters
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            font_x <= FONT_X_FIRST;
            char_index <= REG_RESET;
        end
        else if (clock_en)
        begin
            if (seq_state == SEQ_IDLE || !line_active)
            begin
                font_x <= FONT_X_FIRST;
                char_index <= REG_RESET;
            end
            else if (pixel_tick && (seq_state == SEQ_REPEAT || !cur_wide))
            begin
                // Advance font_x after one copy (1 pixel) or two copies (2 pixels), the character after 12 or 24 pixels
                if (font_x == FONT_X_LAST)
                begin
                    font_x <= FONT_X_FIRST;
                    if (char_index != CHAR_LAST)
                        char_index <= char_index + CHAR_ONE;
                end
                else
                    font_x <= font_x + FONT_X_ONE;
            end
        end
    end

    // Pixel output
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overlay_display_pixel <= 1'b0;
            pixel_valid <= 1'b0;
            wide_column <= 1'b0;
        end
        else if (clock_en)
        begin
            if (seq_state != SEQ_IDLE && line_active && pixel_tick)
            begin
                overlay_display_pixel <= font_bit(font_row, font_x);
                pixel_valid <= 1'b1;
                wide_column <= cur_wide;
            end
            else
            begin
                overlay_display_pixel <= 1'b0;
                pixel_valid <= 1'b0;
                wide_column <= 1'b0;
            end
        end
    end

    assign cfg.blue = blue_gain_ctrl;
    assign cfg.green = green_gain_ctrl;
    assign cfg.red = red_gain_ctrl;
    assign cfg.contrast = contrast_ctrl;
    assign cfg.dac_one = dac_one_level;
    assign cfg.dac_two = dac_two_level;
    assign cfg.dac_three = dac_three_level;
    assign cfg.full_scale_low = full_scale_low;

    owgdr_gain_out u_gain (
        .clock(clock),
        .rst_n(rst_n),
        .clock_en(clock_en),
        .cfg(cfg.gain),
        .blue_gain(blue_gain),
        .green_gain(green_gain),
        .red_gain(red_gain),
        .contrast_level(contrast_level)
    );

    owgdr_dac_out u_dac (
        .clock(clock),
        .rst_n(rst_n),
        .clock_en(clock_en),
        .cfg(cfg.dac),
        .dac_one_value(dac_one_value),
        .dac_two_value(dac_two_value),
        .dac_three_value(dac_three_value),
        .dac_range_low(dac_range_low)
    );
endmodule : owgdr_top

// File: owgdr_pkg.sv
// Purpose: Shared constants for the overlay width, gain and DAC register bank
// Assumes: Byte-wide register port from the serial control front end, same clock
// Notes: All registers reset to zero
//
// Notes on behaviour
// - Mask bit n of window two controls display column n, columns 31 to 0.
// - Clear mask bit gives 12 overlay pixels, set bit gives 24.
// - Wide column repeats every font pixel in two consecutive pixel positions.
// - Characters after the thirty-second on a line are always normal width.
// - Fade register bits 7 to 4 set the vertical fade interval.
// - Fade register bits 3 to 0 set the horizontal fade interval.
// - Blue gain field bits 6 to 0 drives only the blue channel.
// - Green gain field bits 6 to 0 drives only the green channel.
// - Red gain field bits 6 to 0 drives only the red channel.
// - Contrast field at 0x8433 drives one common gain to all channels.
// - First DAC level from its byte register, range from config bit 5.
// - Second DAC level from its byte register, same range bit.
// - Third DAC level from its byte register, range bit at 0x8438.
// - Mask split over four bytes, low addresses bits 15-0, upper 31-16.
// - Range bit clear gives 0.5-4.5 V, set gives 0.5-2.5 V.
package owgdr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int GAIN_W = 7;
    localparam int MASK_W = 32;
    localparam int FONT_W = 12;
    localparam int CHAR_W = 8;
    localparam int FONT_X_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_WIDE_B0 = 16'h841c;
    localparam logic [ADDR_W-1:0] ADDR_WIDE_B1 = 16'h841d;
    localparam logic [ADDR_W-1:0] ADDR_WIDE_B2 = 16'h841e;
    localparam logic [ADDR_W-1:0] ADDR_WIDE_B3 = 16'h841f;
    localparam logic [ADDR_W-1:0] ADDR_FADE = 16'h8429;
    localparam logic [ADDR_W-1:0] ADDR_BLUE = 16'h8430;
    localparam logic [ADDR_W-1:0] ADDR_GREEN = 16'h8431;
    localparam logic [ADDR_W-1:0] ADDR_RED = 16'h8432;
    localparam logic [ADDR_W-1:0] ADDR_CONTRAST = 16'h8433;
    localparam logic [ADDR_W-1:0] ADDR_DAC_ONE = 16'h8434;
    localparam logic [ADDR_W-1:0] ADDR_DAC_TWO = 16'h8435;
    localparam logic [ADDR_W-1:0] ADDR_DAC_THREE = 16'h8436;
    localparam logic [ADDR_W-1:0] ADDR_DAC_CONFIG = 16'h8438;
    localparam int FULL_SCALE_BIT = 5;
    localparam int VFADE_HI = 7;
    localparam int VFADE_LO = 4;
    localparam int HFADE_HI = 3;
    localparam int HFADE_LO = 0;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
    localparam logic [FONT_X_W-1:0] FONT_X_LAST = 4'hb;
    localparam logic [FONT_X_W-1:0] FONT_X_FIRST = 4'h0;
    localparam logic [CHAR_W-1:0] WIDE_CHAR_LIMIT = 8'h20;
    localparam logic [CHAR_W-1:0] CHAR_LAST = 8'hff;
    localparam logic [CHAR_W-1:0] CHAR_ONE = 8'h01;
    localparam logic [FONT_X_W-1:0] FONT_X_ONE = 4'h1;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_FIRST = 2'b01,
        SEQ_REPEAT = 2'b10
    } owgdr_seq_state_t;
endpackage : owgdr_pkg

// File: owgdr_cfg_if.sv
// Purpose: Carries stored register values from the bank to the output stages
// Assumes: Single clock domain
// Notes: Bank drives, stages only read
interface owgdr_cfg_if;
    import owgdr_pkg::*;
    logic [DATA_W-1:0] blue;
    logic [DATA_W-1:0] green;
    logic [DATA_W-1:0] red;
    logic [DATA_W-1:0] contrast;
    logic [DATA_W-1:0] dac_one;
    logic [DATA_W-1:0] dac_two;
    logic [DATA_W-1:0] dac_three;
    logic full_scale_low;
    modport bank (output blue, output green, output red, output contrast,
        output dac_one, output dac_two, output dac_three, output full_scale_low);
    modport gain (input blue, input green, input red, input contrast);
    modport dac (input dac_one, input dac_two, input dac_three, input full_scale_low);
endinterface : owgdr_cfg_if

// File: owgdr_gain_out.sv
// Purpose: Drives per-channel gain and common contrast fields to the analog stage
// Assumes: Synchronised reset from the top
// Notes: Top bit of each register is not passed on
module owgdr_gain_out
    import owgdr_pkg::*;
(
    input logic clock,
    input logic rst_n,
    input logic clock_en,
    owgdr_cfg_if.gain cfg,
    output logic [GAIN_W-1:0] blue_gain,
    output logic [GAIN_W-1:0] green_gain,
    output logic [GAIN_W-1:0] red_gain,
    output logic [GAIN_W-1:0] contrast_level
);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blue_gain <= REG_RESET[GAIN_W-1:0];
            green_gain <= REG_RESET[GAIN_W-1:0];
            red_gain <= REG_RESET[GAIN_W-1:0];
            contrast_level <= REG_RESET[GAIN_W-1:0];
        end
        else if (clock_en)
        begin
            blue_gain <= cfg.blue[GAIN_W-1:0];
            green_gain <= cfg.green[GAIN_W-1:0];
            red_gain <= cfg.red[GAIN_W-1:0];
            contrast_level <= cfg.contrast[GAIN_W-1:0];
        end
    end
endmodule : owgdr_gain_out

// File: owgdr_dac_out.sv
// Purpose: Drives the three DAC levels and their shared range select
// Assumes: Synchronised reset from the top
// Notes: Range low means 0.5 to 2.5 V, otherwise 0.5 to 4.5 V
module owgdr_dac_out
    import owgdr_pkg::*;
(
    input logic clock,
    input logic rst_n,
    input logic clock_en,
    owgdr_cfg_if.dac cfg,
    output logic [DATA_W-1:0] dac_one_value,
    output logic [DATA_W-1:0] dac_two_value,
    output logic [DATA_W-1:0] dac_three_value,
    output logic dac_range_low
);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dac_one_value <= REG_RESET;
            dac_two_value <= REG_RESET;
            dac_three_value <= REG_RESET;
            dac_range_low <= 1'b0;
        end
        else if (clock_en)
        begin
            dac_one_value <= cfg.dac_one;
            dac_two_value <= cfg.dac_two;
            dac_three_value <= cfg.dac_three;
            dac_range_low <= cfg.full_scale_low;
        end
    end
endmodule : owgdr_dac_out

// File: owgdr_props.sv
// Purpose: Checks on the top ports
// Assumes: One clock, arst_n low resets
// Notes: Bound from the testbench
module owgdr_props
    import owgdr_pkg::*;
(
    input logic clock,
    input logic arst_n,
    input logic clock_en,
    input logic [ADDR_W-1:0] host_addr,
    input logic [DATA_W-1:0] host_wdata,
    input logic host_wr,
    input logic host_rd,
    input logic [DATA_W-1:0] host_rdata,
    input logic host_hit,
    input logic pixel_valid,
    input logic wide_column,
    input logic [3:0] vertical_fade_step,
    input logic [3:0] horizontal_fade_step,
    input logic [GAIN_W-1:0] blue_gain,
    input logic [GAIN_W-1:0] green_gain,
    input logic [GAIN_W-1:0] red_gain,
    input logic [GAIN_W-1:0] contrast_level,
    input logic [DATA_W-1:0] dac_one_value,
    input logic [DATA_W-1:0] dac_two_value,
    input logic [DATA_W-1:0] dac_three_value,
    input logic dac_range_low
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    wire wr = clock_en && host_wr;
    wire rd = clock_en && host_rd;
    wire mapped = (host_addr >= ADDR_WIDE_B0 && host_addr <= ADDR_WIDE_B3)
        || host_addr == ADDR_FADE || (host_addr >= ADDR_BLUE && host_addr <= ADDR_DAC_THREE);
    AST_FADE_V:
    assert property (wr && host_addr == ADDR_FADE |=> vertical_fade_step == $past(host_wdata) >> 4)
        else $error("vfade");
    AST_FADE_H:
    assert property (wr && host_addr == ADDR_FADE |=>
        horizontal_fade_step == ($past(host_wdata) & 8'h0f)) else $error("hfade");
    AST_BLUE:
    assert property (wr && host_addr == ADDR_BLUE |=> ##1
        blue_gain == ($past(host_wdata, 2) & 8'h7f)) else $error("blue");
    AST_GREEN:
    assert property (wr && host_addr == ADDR_GREEN |=> ##1
        green_gain == ($past(host_wdata, 2) & 8'h7f)) else $error("green");
    AST_RED:
    assert property (wr && host_addr == ADDR_RED |=> ##1
        red_gain == ($past(host_wdata, 2) & 8'h7f)) else $error("red");
    AST_CONTRAST:
    assert property (wr && host_addr == ADDR_CONTRAST |=> ##1
        contrast_level == ($past(host_wdata, 2) & 8'h7f)) else $error("contrast");
    AST_DAC_ONE:
    assert property (wr && host_addr == ADDR_DAC_ONE |=> ##1
        dac_one_value == $past(host_wdata, 2)) else $error("dac1");
    AST_DAC_TWO:
    assert property (wr && host_addr == ADDR_DAC_TWO |=> ##1
        dac_two_value == $past(host_wdata, 2)) else $error("dac2");
    AST_DAC_THREE:
    assert property (wr && host_addr == ADDR_DAC_THREE |=> ##1
        dac_three_value == $past(host_wdata, 2)) else $error("dac3");
    AST_RANGE:
    assert property (wr && host_addr == ADDR_DAC_CONFIG |=> ##1
        dac_range_low == (($past(host_wdata, 2) & 8'h20) != 8'h00)) else $error("range");
    AST_HIT:
    assert property (rd && mapped |=> host_hit) else $error("no hit");
    AST_NO_HIT:
    assert property (clock_en && !(rd && mapped) |=> !host_hit && host_rdata == READ_IDLE)
        else $error("stray hit");
    AST_WIDE:
    assert property (wide_column |-> pixel_valid) else $error("wide");
endmodule : owgdr_props

// File: owgdr_host_model.sv
// Purpose: Host side of the byte register port
// Assumes: One-cycle strobes
// Notes: Idle lines show inverted last values
module owgdr_host_model
    import owgdr_pkg::*;
(
    input logic clock,
    output logic [ADDR_W-1:0] host_addr,
    output logic [DATA_W-1:0] host_wdata,
    output logic host_wr,
    output logic host_rd,
    input logic [DATA_W-1:0] host_rdata,
    input logic host_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        host_addr = 16'h0000;
        host_wdata = 8'h00;
        host_wr = 1'b0;
        host_rd = 1'b0;
    end
    task automatic release_bus();
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = ~host_addr;
        host_wdata = ~host_wdata;
    endtask : release_bus
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        #1;
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(posedge clock);
        #1;
        release_bus();
    endtask : wr_reg
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
        output logic h);
        @(posedge clock);
        #1;
        host_addr = a;
        host_rd = 1'b1;
        @(posedge clock);
        #1;
        d = host_rdata;
        h = host_hit;
        release_bus();
    endtask : rd_reg
endmodule : owgdr_host_model

// File: owgdr_top_tb.sv
// Purpose: Self-checking bench for the register bank
// Assumes: 125 MHz clock
// Notes: Two overlay lines test the mask
module owgdr_top_tb
    import owgdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCHAR = 34;
    localparam logic [ADDR_W-1:0] ADDRS [12] = '{ADDR_WIDE_B0, ADDR_WIDE_B1, ADDR_WIDE_B2,
        ADDR_WIDE_B3, ADDR_FADE, ADDR_BLUE, ADDR_GREEN, ADDR_RED, ADDR_CONTRAST,
        ADDR_DAC_ONE, ADDR_DAC_TWO, ADDR_DAC_THREE};
    localparam logic [DATA_W-1:0] VALS [12] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h96, 8'h55,
        8'h2a, 8'h71, 8'h0f, 8'hff, 8'h80, 8'h01};
    logic clock, arst_n, clock_en, host_wr, host_rd, host_hit, line_active, pixel_tick;
    logic overlay_display_pixel, pixel_valid, wide_column, dac_range_low;
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_wdata, host_rdata, dac_one_value, dac_two_value, dac_three_value;
    logic [FONT_W-1:0] font_row;
    logic [CHAR_W-1:0] char_index;
    logic [3:0] vertical_fade_step, horizontal_fade_step;
    logic [GAIN_W-1:0] blue_gain, green_gain, red_gain, contrast_level;
    int errors, check_count;
    owgdr_top owgdr_top_inst (.clock(clock), .arst_n(arst_n), .clock_en(clock_en),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
        .host_rdata(host_rdata), .host_hit(host_hit), .line_active(line_active),
        .pixel_tick(pixel_tick), .font_row(font_row), .char_index(char_index),
        .overlay_display_pixel(overlay_display_pixel), .pixel_valid(pixel_valid),
        .wide_column(wide_column), .vertical_fade_step(vertical_fade_step),
        .horizontal_fade_step(horizontal_fade_step), .blue_gain(blue_gain),
        .green_gain(green_gain), .red_gain(red_gain), .contrast_level(contrast_level),
        .dac_one_value(dac_one_value), .dac_two_value(dac_two_value),
        .dac_three_value(dac_three_value), .dac_range_low(dac_range_low));
    owgdr_host_model owgdr_host_model_inst (.clock(clock), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
        .host_rdata(host_rdata), .host_hit(host_hit));
    function automatic logic [FONT_W-1:0] pat(input logic [CHAR_W-1:0] c);
        return 12'h9a6 ^ {c, 4'h0};
    endfunction : pat
    always_comb font_row = pat(char_index);
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic conclude();
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic cmp(input string name, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : cmp
    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic h);
        logic [DATA_W-1:0] got;
        logic hit;
        owgdr_host_model_inst.rd_reg(a, got, hit);
        cmp("rdata", d, got);
        cmp("hit", h, hit);
    endtask : chk_rd
    task automatic run_line(input logic [MASK_W-1:0] m);
        int c, k, w, issued, seen, total;
        logic [FONT_W-1:0] f;
        for (int b = 0; b < 4; b++)
            owgdr_host_model_inst.wr_reg(ADDRS[b], m[8*b +: 8]);
        total = 0;
        for (int i = 0; i < NCHAR; i++)
            total += (i < 32 && m[i]) ? 24 : 12;
        c = 0;
        k = 0;
        issued = 0;
        seen = 0;
        line_active = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        pixel_tick = 1'b1;
        for (int g = 0; g < 2000 && seen < total; g++)
        begin
            @(posedge clock);
            #1;
            if (pixel_tick)
                issued++;
            if (issued == total)
                pixel_tick = 1'b0;
            if (pixel_valid === 1'b1)
            begin
                w = (c < 32 && m[c]) ? 24 : 12;
                f = pat(8'(c));
                cmp("pixel", f[11 - ((w == 24) ? k / 2 : k)], overlay_display_pixel);
                cmp("wide", w == 24, wide_column);
                k++;
                seen++;
                if (k == w)
                begin
                    c++;
                    k = 0;
                end
            end
        end
        cmp("pixel count", total, seen);
        cmp("chars", NCHAR, char_index);
        line_active = 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask : run_line
    initial
    begin
        #100000;
        errors++;
        conclude();
    end
    initial
    begin
        arst_n = 1'b0;
        clock_en = 1'b1;
        line_active = 1'b0;
        pixel_tick = 1'b0;
        errors = 0;
        check_count = 0;
        repeat (16) @(posedge clock);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 12; i++)
            chk_rd(ADDRS[i], REG_RESET, 1'b1);
        for (int i = 0; i < 12; i++)
            owgdr_host_model_inst.wr_reg(ADDRS[i], VALS[i]);
        for (int i = 0; i < 12; i++)
            chk_rd(ADDRS[i], VALS[i], 1'b1);
        cmp("vfade", VALS[4] >> 4, vertical_fade_step);
        cmp("hfade", VALS[4] & 8'h0f, horizontal_fade_step);
        cmp("blue", VALS[5] & 8'h7f, blue_gain);
        cmp("green", VALS[6] & 8'h7f, green_gain);
        cmp("red", VALS[7] & 8'h7f, red_gain);
        cmp("contrast", VALS[8] & 8'h7f, contrast_level);
        cmp("dac one", VALS[9], dac_one_value);
        cmp("dac two", VALS[10], dac_two_value);
        cmp("dac three", VALS[11], dac_three_value);
        owgdr_host_model_inst.wr_reg(ADDR_DAC_CONFIG, 8'h20);
        chk_rd(ADDR_DAC_CONFIG, READ_IDLE, 1'b0);
        cmp("range set", 1'b1, dac_range_low);
        owgdr_host_model_inst.wr_reg(ADDR_DAC_CONFIG, 8'hdf);
        chk_rd(16'h8437, READ_IDLE, 1'b0);
        cmp("range clear", 1'b0, dac_range_low);
        owgdr_host_model_inst.wr_reg(16'h8428, 8'h77);
        clock_en = 1'b0;
        owgdr_host_model_inst.wr_reg(ADDR_BLUE, 8'h7f);
        clock_en = 1'b1;
        chk_rd(ADDR_BLUE, VALS[5], 1'b1);
        chk_rd(16'h8428, READ_IDLE, 1'b0);
        run_line(32'h8000_0002);
        run_line(32'hffff_ffff);
        arst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clock);
        chk_rd(ADDR_DAC_ONE, REG_RESET, 1'b1);
        cmp("dac one reset", REG_RESET, dac_one_value);
        conclude();
    end
endmodule : owgdr_top_tb
bind owgdr_top owgdr_props owgdr_props_inst (.clock(clock), .arst_n(arst_n),
    .clock_en(clock_en), .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata), .host_hit(host_hit),
    .pixel_valid(pixel_valid), .wide_column(wide_column),
    .vertical_fade_step(vertical_fade_step), .horizontal_fade_step(horizontal_fade_step),
    .blue_gain(blue_gain), .green_gain(green_gain), .red_gain(red_gain),
    .contrast_level(contrast_level), .dac_one_value(dac_one_value),
    .dac_two_value(dac_two_value), .dac_three_value(dac_three_value),
    .dac_range_low(dac_range_low));
